// ---- verilog/instr_exec_pkg.sv ----
package instr_exec_pkg;

    // ------------------------------------------------------------------
    // Data path sizes
    // ------------------------------------------------------------------
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 7;
    localparam int INSTR_W   = 14;
    localparam int FILE_DEPTH = 128;

    // ------------------------------------------------------------------
    // Instruction encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] CLS_LITERAL   = 2'h3;
    localparam logic [1:0] CLS_BYTE_FILE = 2'h0;
    localparam logic [3:0] OP_OR_LIT     = 4'h8;   // Bits 11:8 of the or-literal word.
    localparam logic [1:0] OP_LOAD_LIT   = 2'h0;   // Bits 11:10 of the load-literal word.
    localparam logic [3:0] OP_COPY_FILE  = 4'h8;
    localparam logic [3:0] OP_MISC       = 4'h0;   // Store and no-operation share this group.
    localparam logic [4:0] NOP_LOW_BITS  = 5'h00;

    // Instruction word split into its fields; the literal is {dest, addr}.
    typedef struct packed {
        logic [1:0]        cls;
        logic [3:0]        op;
        logic              dest;
        logic [ADDR_W-1:0] addr;
    } instr_t;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h4;
    localparam int CTRL_ENABLE_BIT     = 0;
    localparam int CTRL_CLR_UNSUP_BIT  = 1;
    localparam int STAT_ZERO_BIT       = 8;
    localparam int STAT_UNSUP_BIT      = 9;
    localparam logic CTRL_ENABLE_RST   = 1'b0;
    localparam logic [7:0] ACC_RST     = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // AXI write channel progress.
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP    = 2'b10
    } wr_state_t;

endpackage : instr_exec_pkg

// ---- verilog/file_reg_array.sv ----
`timescale 1ns/1ns
module file_reg_array #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_n_in,
    // Write port
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    // Read port, data one cycle after the address
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // A read of a word written on the same edge returns the old value; the caller forwards.
    always_ff @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // Registered read data.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule : file_reg_array

// ---- verilog/literal_and_move_instr_exec.sv ----
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
// Summary of operation
// RULE1: Or-literal ORs the low byte into the accumulator, sets zero flag, one cycle.
// RULE2: Load-literal puts the low byte in the accumulator; flags untouched, don't-cares ignored.
// RULE3: Copy-file-register reads the addressed register and routes it by destination bit.
// RULE4: Copy with destination bit 0 writes the value into the accumulator.
// RULE5: Copy with destination bit 1 writes it back to the register; accumulator kept.
// RULE6: Copy updates the zero flag from the moved value for either destination.
// RULE7: Store writes the accumulator into the addressed register; flags and accumulator kept.
// RULE8: No-operation changes nothing and only advances the program counter.
module literal_and_move_instr_exec
    import instr_exec_pkg::*;
(
    // Clock and reset
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_n_in,
    // Instruction stream
    input  wire instr_exec_pkg::instr_t       instr_in,
    input  wire logic                         instr_valid_in,
    output logic                              instr_ready_out,
    // Core state
    output logic [instr_exec_pkg::DATA_W-1:0] acc_out,
    output logic                              zero_flag_out,
    output logic                              pc_advance_out,
    // AXI4-Lite slave
    input  wire logic [3:0]                   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [3:0]                   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready
);
    import instr_exec_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic              ex_v_r, ex_v_nxt;
    instr_t            ex_i_r, ex_i_nxt;
    logic [DATA_W-1:0] acc_r, acc_nxt;
    logic              zero_r, zero_nxt;
    logic              adv_r, adv_nxt;
    logic              unsup_r, unsup_nxt;
    logic              fw_v_r, fw_v_nxt;
    logic [ADDR_W-1:0] fw_a_r, fw_a_nxt;
    logic [DATA_W-1:0] fw_d_r, fw_d_nxt;
    logic              en_r, en_nxt;
    logic [DATA_W-1:0] rd_data, fval, lit;
    logic              wr_en;
    logic [DATA_W-1:0] wr_data;
    logic              is_or, is_load, is_copy, is_store, is_nop;
    wr_state_t         ws_r, ws_nxt;
    logic              aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [3:0]        awa_r, awa_nxt;
    logic [31:0]       wd_r, wd_nxt;
    logic              ws_b0_r, ws_b0_nxt;
    logic [1:0]        bresp_r, bresp_nxt;
    logic              rv_r, rv_nxt;
    logic [31:0]       rd_r, rd_nxt;
    logic [1:0]        rresp_r, rresp_nxt;
    logic              clr_unsup;

    // ------------------------------------------------------------------
    // File register array
    // ------------------------------------------------------------------
    file_reg_array #(.WIDTH(DATA_W), .DEPTH(FILE_DEPTH), .AW(ADDR_W)) u_files (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .wr_en_in    (wr_en),
        .wr_addr_in  (ex_i_r.addr),
        .wr_data_in  (wr_data),
        .rd_addr_in  (instr_in.addr),
        .rd_data_out (rd_data)
    );

    // ------------------------------------------------------------------
    // Decode of the executing word
    // ------------------------------------------------------------------
    // The array answers a cycle late, so a write made on the issue edge is forwarded.
    assign instr_ready_out = en_r;
    assign lit      = {ex_i_r.dest, ex_i_r.addr};
    assign fval     = (fw_v_r && fw_a_r == ex_i_r.addr) ? fw_d_r : rd_data;
    assign is_or    = ex_v_r && ex_i_r.cls == CLS_LITERAL && ex_i_r.op == OP_OR_LIT;            // [RULE1]
    assign is_load  = ex_v_r && ex_i_r.cls == CLS_LITERAL && ex_i_r.op[3:2] == OP_LOAD_LIT;     // [RULE2]
    assign is_copy  = ex_v_r && ex_i_r.cls == CLS_BYTE_FILE && ex_i_r.op == OP_COPY_FILE;       // [RULE3]
    assign is_store = ex_v_r && ex_i_r.cls == CLS_BYTE_FILE && ex_i_r.op == OP_MISC && ex_i_r.dest; // [RULE7]
    assign is_nop   = ex_v_r && ex_i_r.cls == CLS_BYTE_FILE && ex_i_r.op == OP_MISC && !ex_i_r.dest
                      && ex_i_r.addr[4:0] == NOP_LOW_BITS;                                      // [RULE8]
    assign wr_en    = is_store || (is_copy && ex_i_r.dest);                                     // [RULE5]
    assign wr_data  = is_store ? acc_r : fval;                                                  // [RULE7]

    // ------------------------------------------------------------------
    // Execute next state
    // ------------------------------------------------------------------
    // Words outside this slice retire as no-operations and raise a sticky flag.
    always_comb begin
        ex_v_nxt  = instr_valid_in && en_r;
        ex_i_nxt  = instr_in;
        acc_nxt   = acc_r;
        zero_nxt  = zero_r;
        adv_nxt   = ex_v_r;                                                  // [RULE8]
        fw_v_nxt  = wr_en;
        fw_a_nxt  = ex_i_r.addr;
        fw_d_nxt  = wr_data;
        unsup_nxt = unsup_r && !clr_unsup;
        if (is_or) begin
            acc_nxt  = acc_r | lit;                                          // [RULE1]
            zero_nxt = (acc_r | lit) == '0;                                  // [RULE1]
        end else if (is_load) begin
            acc_nxt  = lit;                                                  // [RULE2]
        end else if (is_copy) begin
            if (!ex_i_r.dest) begin
                acc_nxt = fval;                                              // [RULE4]
            end
            zero_nxt = fval == '0;                                           // [RULE6]
        end else if (ex_v_r && !is_store && !is_nop) begin
            unsup_nxt = 1'b1;   // Set wins over a clear in the same cycle.
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ex_v_r  <= 1'b0;
            ex_i_r  <= '0;
            acc_r   <= ACC_RST;
            zero_r  <= 1'b0;
            adv_r   <= 1'b0;
            fw_v_r  <= 1'b0;
            fw_a_r  <= '0;
            fw_d_r  <= '0;
            unsup_r <= 1'b0;
        end else begin
            ex_v_r  <= ex_v_nxt;
            ex_i_r  <= ex_i_nxt;
            acc_r   <= acc_nxt;
            zero_r  <= zero_nxt;
            adv_r   <= adv_nxt;
            fw_v_r  <= fw_v_nxt;
            fw_a_r  <= fw_a_nxt;
            fw_d_r  <= fw_d_nxt;
            unsup_r <= unsup_nxt;
        end
    end

    assign acc_out        = acc_r;
    assign zero_flag_out  = zero_r;
    assign pc_advance_out = adv_r;

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    // Address and data are collected in either order; the write lands when both are in.
    always_comb begin
        logic aw_now, w_now;
        aw_now     = 1'b0;
        w_now      = 1'b0;
        ws_nxt     = ws_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        awa_nxt    = awa_r;
        wd_nxt     = wd_r;
        ws_b0_nxt  = ws_b0_r;
        bresp_nxt  = bresp_r;
        en_nxt     = en_r;
        clr_unsup  = 1'b0;
        unique case (ws_r)
            WR_COLLECT: begin
                aw_now = aw_got_r || s_axi_awvalid;
                w_now  = w_got_r || s_axi_wvalid;
                if (s_axi_awvalid && !aw_got_r) begin
                    aw_got_nxt = 1'b1;
                    awa_nxt    = s_axi_awaddr;
                end
                if (s_axi_wvalid && !w_got_r) begin
                    w_got_nxt = 1'b1;
                    wd_nxt    = s_axi_wdata;
                    ws_b0_nxt = s_axi_wstrb[0];
                end
                if (aw_now && w_now) begin
                    ws_nxt     = WR_RESP;
                    aw_got_nxt = 1'b0;
                    w_got_nxt  = 1'b0;
                    bresp_nxt  = RESP_SLVERR;
                    if (awa_nxt == OFS_CTRL) begin
                        bresp_nxt = RESP_OKAY;
                        if (ws_b0_nxt) begin
                            en_nxt    = wd_nxt[CTRL_ENABLE_BIT];
                            clr_unsup = wd_nxt[CTRL_CLR_UNSUP_BIT];
                        end
                    end else if (awa_nxt == OFS_STATUS) begin
                        bresp_nxt = RESP_OKAY;  // Status is read-only; writes are dropped.
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    ws_nxt = WR_COLLECT;
                end
            end
        endcase
        rv_nxt    = rv_r && !s_axi_rready;
        rd_nxt    = rd_r;
        rresp_nxt = rresp_r;
        if (!rv_r && s_axi_arvalid) begin
            rv_nxt    = 1'b1;
            rd_nxt    = '0;
            rresp_nxt = RESP_OKAY;
            if (s_axi_araddr == OFS_CTRL) begin
                rd_nxt[CTRL_ENABLE_BIT] = en_r;
            end else if (s_axi_araddr == OFS_STATUS) begin
                rd_nxt[DATA_W-1:0]     = acc_r;
                rd_nxt[STAT_ZERO_BIT]  = zero_r;
                rd_nxt[STAT_UNSUP_BIT] = unsup_r;
            end else begin
                rresp_nxt = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ws_r     <= WR_COLLECT;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awa_r    <= '0;
            wd_r     <= '0;
            ws_b0_r  <= 1'b0;
            bresp_r  <= RESP_OKAY;
            en_r     <= CTRL_ENABLE_RST;
            rv_r     <= 1'b0;
            rd_r     <= '0;
            rresp_r  <= RESP_OKAY;
        end else begin
            ws_r     <= ws_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r  <= w_got_nxt;
            awa_r    <= awa_nxt;
            wd_r     <= wd_nxt;
            ws_b0_r  <= ws_b0_nxt;
            bresp_r  <= bresp_nxt;
            en_r     <= en_nxt;
            rv_r     <= rv_nxt;
            rd_r     <= rd_nxt;
            rresp_r  <= rresp_nxt;
        end
    end

    assign s_axi_awready = ws_r == WR_COLLECT && !aw_got_r;
    assign s_axi_wready  = ws_r == WR_COLLECT && !w_got_r;
    assign s_axi_bvalid  = ws_r == WR_RESP;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rv_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rdata   = rd_r;
    assign s_axi_rresp   = rresp_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_issue;
        instr_valid_in && instr_ready_out;
    endsequence
    sequence s_retire;
        pc_advance_out;
    endsequence

    property p_or_lit;
        is_or |=> acc_out == ($past(acc_r) | $past(lit)) && zero_flag_out == (acc_out == 8'h00);
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("or-literal result wrong"); // [RULE1]

    property p_load_lit;
        is_load |=> acc_out == $past(lit) && zero_flag_out == $past(zero_r);
    endproperty
    a_load_lit: assert property (p_load_lit) else $error("load-literal result wrong"); // [RULE2]

    property p_copy_issue;
        s_issue ##1 is_copy |-> !wr_en || !ex_i_r.dest || wr_data == fval;
    endproperty
    a_copy_issue: assert property (p_copy_issue) else $error("copy routed wrong value"); // [RULE3]

    property p_copy_acc;
        is_copy && !ex_i_r.dest |-> !wr_en ##1 acc_out == $past(fval);
    endproperty
    a_copy_acc: assert property (p_copy_acc) else $error("copy to accumulator wrong"); // [RULE4]

    property p_copy_file;
        is_copy && ex_i_r.dest |-> wr_en && wr_data == fval ##1 $stable(acc_out);
    endproperty
    a_copy_file: assert property (p_copy_file) else $error("copy to file wrong"); // [RULE5]

    property p_copy_zero;
        is_copy |=> zero_flag_out == ($past(fval) == 8'h00);
    endproperty
    a_copy_zero: assert property (p_copy_zero) else $error("copy zero flag wrong"); // [RULE6]

    property p_store;
        is_store |-> wr_en && wr_data == acc_out ##1 $stable(acc_out) && $stable(zero_flag_out);
    endproperty
    a_store: assert property (p_store) else $error("store wrong"); // [RULE7]

    property p_nop;
        is_nop |-> !wr_en ##1 (($stable(acc_out) && $stable(zero_flag_out)) and s_retire);
    endproperty
    a_nop: assert property (p_nop) else $error("no-operation changed state"); // [RULE8]

    property p_one_cycle;
        s_issue |-> ##2 s_retire;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("instruction did not retire in time"); // [RULE1]
endmodule : literal_and_move_instr_exec

// ---- dv/test_literal_and_move_instr_exec.sv ----
`timescale 1ns/1ns
module test_literal_and_move_instr_exec;
    import instr_exec_pkg::*;

    // ------------------------------------------------------------------
    // Stimulus, model state and bookkeeping
    // ------------------------------------------------------------------
    logic             ref_clk_in;
    logic             rst_n_in;
    instr_t           instr_in;
    logic             instr_valid_in;
    logic             instr_ready_out;
    logic [7:0]       acc_out;
    logic             zero_flag_out;
    logic             pc_advance_out;
    logic [3:0]       s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0]      s_axi_wdata, s_axi_rdata;
    logic [1:0]       s_axi_bresp, s_axi_rresp;
    logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic             s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]       mem_m [128];
    logic [7:0]       acc_m;
    logic             z_m;
    logic [8:0]       iq [$];
    logic [33:0]      rq [$];
    logic [33:0]      bq [$];
    int               n_mismatch, tests_run, cycles;

    literal_and_move_instr_exec dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
        .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out), .acc_out(acc_out),
        .zero_flag_out(zero_flag_out), .pc_advance_out(pc_advance_out), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    // Free-running 20 MHz clock.
    initial ref_clk_in = 1'b0;
    always #25 ref_clk_in = ~ref_clk_in;

    // ------------------------------------------------------------------
    // Compare and close
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("comparisons=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // A hang must not run forever; the whole test needs about 800 cycles.
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_d, w_d;
        @(posedge ref_clk_in);
        aw_d = 1'b0;
        w_d = 1'b0;
        bq.push_back({er, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Each channel is released on its own acceptance edge.
        while (!(aw_d && w_d)) begin
            @(posedge ref_clk_in);
            if (!aw_d && s_axi_awready === 1'b1) begin
                aw_d = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_d && s_axi_wready === 1'b1) begin
                w_d = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk_in); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge ref_clk_in);
        rq.push_back({er, ed});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk_in); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk_in); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // Offers one word, waits for it to be taken, then advances the model.
    task automatic issue(input instr_t w);
        logic [7:0] v;
        instr_in <= w;
        instr_valid_in <= 1'b1;
        do @(posedge ref_clk_in); while (instr_ready_out !== 1'b1);
        v = mem_m[w.addr];
        if (w.cls == CLS_LITERAL && w.op == OP_OR_LIT) begin
            acc_m = acc_m | {w.dest, w.addr};
            z_m = (acc_m == 8'h00);
        end else if (w.cls == CLS_LITERAL && w.op[3:2] == OP_LOAD_LIT) begin
            acc_m = {w.dest, w.addr};
        end else if (w.op == OP_COPY_FILE) begin
            if (!w.dest)
                acc_m = v;
            z_m = (v == 8'h00);
        end else if (w.dest) begin
            mem_m[w.addr] = acc_m;
        end
        iq.push_back({z_m, acc_m});
    endtask : issue

    // Builds one legal word of the chosen kind; zero literals are frequent to exercise the flag.
    function automatic instr_t rand_instr(input int unsigned k, input logic [6:0] a);
        logic [7:0] lit;
        lit = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
        case (k)
            0: return {CLS_LITERAL, OP_OR_LIT, lit};
            1: return {CLS_LITERAL, OP_LOAD_LIT, 2'($urandom), lit};
            2: return {CLS_BYTE_FILE, OP_COPY_FILE, 1'($urandom), a};
            3: return {CLS_BYTE_FILE, OP_MISC, 1'b1, a};
            default: return {CLS_BYTE_FILE, OP_MISC, 1'b0, 2'($urandom), NOP_LOW_BITS};
        endcase
    endfunction : rand_instr

    // ------------------------------------------------------------------
    // Output monitor: every retire and every bus answer consumes a note
    // ------------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        logic [33:0] e;
        if (rst_n_in === 1'b1) begin
            if (pc_advance_out === 1'b1) begin
                check({23'h0, zero_flag_out, acc_out}, {23'h0, iq.pop_front()});
            end
            if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
                e = rq.pop_front();
                check({30'h0, s_axi_rresp}, {30'h0, e[33:32]});
                check(s_axi_rdata, e[31:0]);
            end
            if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
                e = bq.pop_front();
                check({30'h0, s_axi_bresp}, {30'h0, e[33:32]});
            end
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_n_in, instr_valid_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        instr_in = '0;
        s_axi_wstrb = 4'hf;
        {n_mismatch, tests_run, cycles} = '0;
        acc_m = 8'h00;
        z_m = 1'b0;
        void'($urandom(54));
        repeat (16) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        // Reset values, unmapped places and the read-only status word.
        axi_read(OFS_CTRL, 32'h0, RESP_OKAY);
        axi_read(OFS_STATUS, 32'h0, RESP_OKAY);
        axi_read(4'h8, 32'h0, RESP_SLVERR);
        axi_write(4'hc, 32'h1, RESP_SLVERR);
        axi_write(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
        axi_read(OFS_STATUS, 32'h0, RESP_OKAY);
        // While disabled an offered word must be ignored; a retire here would pop an empty queue.
        instr_in <= {CLS_LITERAL, OP_LOAD_LIT, 2'h0, 8'h5a};
        instr_valid_in <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        check({31'h0, instr_ready_out}, 32'h0);
        instr_valid_in <= 1'b0;
        axi_write(OFS_CTRL, 32'h3, RESP_OKAY);
        axi_read(OFS_CTRL, 32'h1, RESP_OKAY);
        // Literal boundary cases, then a load that must keep the set flag.
        issue({CLS_LITERAL, OP_LOAD_LIT, 2'h3, 8'h9a});
        issue({CLS_LITERAL, OP_OR_LIT, 8'h35});
        issue({CLS_LITERAL, OP_LOAD_LIT, 2'h1, 8'h00});
        issue({CLS_LITERAL, OP_OR_LIT, 8'h00});
        issue({CLS_LITERAL, OP_LOAD_LIT, 2'h2, 8'h5a});
        // Give every file register a known value.
        for (int i = 0; i < 128; i++) begin
            issue(rand_instr(1, 7'h0));
            issue(rand_instr(3, 7'(i)));
        end
        // Random back-to-back mix on a few addresses, with occasional idle cycles.
        for (int i = 0; i < 400; i++) begin
            if ($urandom % 5 == 0) begin
                instr_valid_in <= 1'b0;
                @(posedge ref_clk_in);
            end
            issue(rand_instr($urandom % 5, 7'($urandom % 8)));
        end
        // A word outside the slice retires as a no-operation and raises the sticky flag.
        issue({CLS_LITERAL, 4'hf, 8'h00});
        instr_valid_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        axi_read(OFS_STATUS, {22'h0, 1'b1, z_m, acc_m}, RESP_OKAY);
        // Writing the clear bit drops the sticky flag and keeps the block enabled.
        axi_write(OFS_CTRL, 32'h3, RESP_OKAY);
        axi_read(OFS_STATUS, {22'h0, 1'b0, z_m, acc_m}, RESP_OKAY);
        repeat (2) @(posedge ref_clk_in);
        check(32'(iq.size()), 32'h0);
        complete_run();
    end

endmodule : test_literal_and_move_instr_exec
